// ==== rtl/pfd_pkg.sv ====
// Constants of the PLL feedback divider: register map, fields, resets.
// Assumes a 32-bit AHB-Lite slave port with word-aligned transfers.
//
// Overview of operation
// - Output is input over integer, edges aligned
// - Software loads division ratios at run time
// - Fixed prescaler precedes programmable counter; here P is set by software in the PRE register
// - Prescaler mode divides by P times N
// - Step size is reference times P over M
// - Swallow mode prescaler divides P or P+1
// - Programmable counter N plus swallow counter S
// - Swallow counting means prescaler divides P+1
// - Both count prescaler output; keep S below N
// - Swallow done switches prescaler to P
// - Swallow mode divides by P times N plus S
`default_nettype none

package pfd_pkg;
    // Decoded byte address bits
    localparam int unsigned PFD_AW = 8;
    // Widths of the ratio fields
    localparam int unsigned PFD_PW = 8;
    localparam int unsigned PFD_NW = 16;
    // Register byte offsets
    localparam logic [7:0] PFD_CTRL_OFF = 8'h00;
    localparam logic [7:0] PFD_PRE_OFF = 8'h04;
    localparam logic [7:0] PFD_NDIV_OFF = 8'h08;
    localparam logic [7:0] PFD_SDIV_OFF = 8'h0c;
    localparam logic [7:0] PFD_STAT_OFF = 8'h10;
    localparam logic [7:0] PFD_PER_OFF = 8'h14;
    // Control fields
    localparam int unsigned PFD_CTRL_EN = 0;
    localparam int unsigned PFD_CTRL_SW = 1;
    // Status fields
    localparam int unsigned PFD_ST_PLUS1 = 0;
    localparam int unsigned PFD_ST_RUN = 1;
    localparam int unsigned PFD_ST_CFGERR = 2;
    localparam int unsigned PFD_ST_NCNT = 16;
    // Reset values
    localparam logic [1:0] PFD_CTRL_RST = 2'h0;
    localparam logic [7:0] PFD_PRE_RST = 8'h02;
    localparam logic [15:0] PFD_NDIV_RST = 16'h01c7;
    localparam logic [15:0] PFD_SDIV_RST = 16'h0000;
    // AHB encodings
    localparam logic [2:0] PFD_HSIZE_WORD = 3'h2;
    localparam logic PFD_HRESP_OKAY = 1'b0;
endpackage

`default_nettype wire

// ==== rtl/pfd_stepcnt.sv ====
// Loadable event counter that wraps after a programmed ratio.
// Assumes step pulses are single cycles from the same clock domain.
`default_nettype none

module pfd_stepcnt #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic restart,
    input wire logic step,
    input wire logic [W-1:0] ratio,
    // State
    output logic [W-1:0] count,
    output logic wrap
);
    // Current position within the ratio
    logic [W-1:0] cnt_q;
    // Last position, ratio zero behaves as one
    logic [W-1:0] last;

    assign last = (ratio == '0) ? '0 : ratio - W'(1);
    // Greater-or-equal so a shrinking ratio never locks the count
    assign wrap = step && (cnt_q >= last);
    assign count = cnt_q;

    // Count steps, return to zero on wrap or restart
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_q <= '0;
        else if (restart || wrap)
            cnt_q <= '0;
        else if (step)
            cnt_q <= cnt_q + W'(1);
    end
endmodule

`default_nettype wire

// ==== rtl/pfd_divider.sv ====
// Feedback divider of a PLL synthesizer, with AHB-Lite registers.
// Assumes the oscillator signal is well below half the bus clock,
// so every rising edge is seen after the two-stage synchroniser.
`default_nettype none

module pfd_divider
    import pfd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // AHB-Lite slave port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Oscillator side
    input wire logic vco_in,
    // Detector side
    output logic fb_out,
    output logic mod_plus1
);
    // Synchroniser for the oscillator pin
    logic vco_s1_q;
    logic vco_s2_q;
    // Delayed copy for edge detection
    logic vco_s3_q;
    // One-cycle pulse per oscillator rising edge
    logic in_rise;

    // Software registers
    logic [1:0] ctrl_q;
    logic [PFD_PW-1:0] pre_q;
    logic [PFD_NW-1:0] ndiv_q;
    logic [PFD_NW-1:0] sdiv_q;
    logic cfgerr_q;
    logic [31:0] per_q;

    // Ratios in force for the current output period
    logic [PFD_PW-1:0] p_act_q;
    logic [PFD_NW-1:0] n_act_q;
    logic [PFD_NW-1:0] s_act_q;
    // Swallow counter still counting
    logic sw_run_q;
    // Divider running
    logic run_q;
    // Registered feedback output
    logic fb_q;

    // Bus data-phase state
    logic wr_pend_q;
    logic [PFD_AW-1:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hready_q;

    // Prescaler ratio in force, P or P+1
    logic [PFD_PW:0] presc_ratio;
    // Prescaler output pulse, one per P or P+1 edges
    logic presc_tc;
    // Programmable counter wrap, ends an output period
    logic period_end;
    // Swallow counter reached S
    logic sw_done;
    // Take new ratios in this cycle
    logic load_act;
    // Live programmable count, shown in status
    logic [PFD_NW-1:0] n_cnt;

    // Address phase taken by this slave
    logic addr_ok;
    // Low address bits of the address phase
    logic [PFD_AW-1:0] rd_addr;
    // One write strobe per register, data phase
    logic wr_ctrl;
    logic wr_pre;
    logic wr_ndiv;
    logic wr_sdiv;
    logic wr_stat;
    logic wr_per;
    // Read data selected in the address phase
    logic [31:0] rd_mux;
    // Status word assembled from live flags
    logic [31:0] stat_word;

    // Configuration error candidates
    logic sw_mode_next;
    logic cfg_bad;

    // Two flops before anything reads the pin
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vco_s1_q <= 1'b0;
            vco_s2_q <= 1'b0;
            vco_s3_q <= 1'b0;
        end
        else
        begin
            // Stage one may go metastable; only stage two reads it
            vco_s1_q <= vco_in;
            vco_s2_q <= vco_s1_q;
            // Edge flop, fed from a clean stage
            vco_s3_q <= vco_s2_q;
        end
    end

    // Rising edge of the synchronised oscillator
    assign in_rise = vco_s2_q && !vco_s3_q;

    // Ratios are taken from the registers while idle and at each
    // period end, so a change never cuts a period short
    assign load_act = !run_q || period_end;

    // Prescaler ratio P, or P+1 while the swallow counter runs
    assign presc_ratio = {1'b0, p_act_q}
        + {{PFD_PW{1'b0}}, sw_run_q};

    // Prescaler: fast divider counting oscillator edges
    pfd_stepcnt #(
        .W(PFD_PW + 1)
    ) u_presc (
        .clk(clk),
        .arst_n(arst_n),
        .restart(!run_q),
        .step(run_q && in_rise),
        .ratio(presc_ratio),
        .count(),
        .wrap(presc_tc)
    );

    // Programmable counter N fed by the prescaler output
    pfd_stepcnt #(
        .W(PFD_NW)
    ) u_prog (
        .clk(clk),
        .arst_n(arst_n),
        .restart(!run_q),
        .step(presc_tc),
        .ratio(n_act_q),
        .count(n_cnt),
        .wrap(period_end)
    );

    // Swallow counter S counting the same prescaler output
    pfd_stepcnt #(
        .W(PFD_NW)
    ) u_swal (
        .clk(clk),
        .arst_n(arst_n),
        .restart(load_act),
        .step(presc_tc && sw_run_q),
        .ratio(s_act_q),
        .count(),
        .wrap(sw_done)
    );

    // Swallow mode bit that the next period will use
    assign sw_mode_next = ctrl_q[PFD_CTRL_SW];
    // S not below N breaks the swallow scheme
    assign cfg_bad = sw_mode_next && (sdiv_q >= ndiv_q);

    // Run flag follows the enable bit
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            run_q <= 1'b0;
        else
            run_q <= ctrl_q[PFD_CTRL_EN];
    end

    // Latch ratios at period boundaries
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            p_act_q <= PFD_PRE_RST;
            n_act_q <= PFD_NDIV_RST;
            s_act_q <= PFD_SDIV_RST;
        end
        else if (load_act)
        begin
            // New P and N hold for the whole next period
            p_act_q <= pre_q;
            n_act_q <= ndiv_q;
            // Prescaler mode ignores S entirely
            s_act_q <= sw_mode_next ? sdiv_q : '0;
        end
    end

    // Modulus control: plus-one from period start until S is done.
    // With S zero or in prescaler mode it stays at plain P, so the
    // whole ratio is P*N+S; each unit of S adds one input cycle.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sw_run_q <= 1'b0;
        else if (load_act)
            sw_run_q <= sw_mode_next && (sdiv_q != '0);
        // S done: plain P for the rest of the period
        else if (sw_done)
            sw_run_q <= 1'b0;
    end

    // Output goes high on the input edge that ends a period and low
    // on the next input edge; both edges follow oscillator edges.
    // A total ratio of one therefore holds the output high.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            fb_q <= 1'b0;
        // Disabled: output parked low
        else if (!run_q)
            fb_q <= 1'b0;
        // Period end: output rises
        else if (period_end)
            fb_q <= 1'b1;
        // Next oscillator edge: output falls
        else if (in_rise)
            fb_q <= 1'b0;
    end

    // Bus address phase accepted
    assign addr_ok = hsel && hready && htrans[1];
    assign rd_addr = haddr[PFD_AW-1:0];

    // Capture a write for its data phase, whole words only
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end
        else
        begin
            // Non-word writes are dropped here
            wr_pend_q <= addr_ok && hwrite && (hsize == PFD_HSIZE_WORD);
            // Address kept for the data phase
            wr_addr_q <= rd_addr;
        end
    end

    // Write strobes in the data phase
    assign wr_ctrl = wr_pend_q && (wr_addr_q == PFD_CTRL_OFF);
    assign wr_pre = wr_pend_q && (wr_addr_q == PFD_PRE_OFF);
    assign wr_ndiv = wr_pend_q && (wr_addr_q == PFD_NDIV_OFF);
    assign wr_sdiv = wr_pend_q && (wr_addr_q == PFD_SDIV_OFF);
    assign wr_stat = wr_pend_q && (wr_addr_q == PFD_STAT_OFF);
    assign wr_per = wr_pend_q && (wr_addr_q == PFD_PER_OFF);

    // Control and ratio registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= PFD_CTRL_RST;
            pre_q <= PFD_PRE_RST;
            ndiv_q <= PFD_NDIV_RST;
            sdiv_q <= PFD_SDIV_RST;
        end
        else
        begin
            // Ratios land here; counters take them at a period end
            if (wr_ctrl)
                ctrl_q <= hwdata[1:0];
            if (wr_pre)
                pre_q <= hwdata[PFD_PW-1:0];
            if (wr_ndiv)
                ndiv_q <= hwdata[PFD_NW-1:0];
            if (wr_sdiv)
                sdiv_q <= hwdata[PFD_NW-1:0];
        end
    end

    // Sticky error: set when a bad swallow setup is taken,
    // write one to clear; a new error in the same cycle wins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cfgerr_q <= 1'b0;
        else if (load_act && ctrl_q[PFD_CTRL_EN] && cfg_bad)
            cfgerr_q <= 1'b1;
        // Cleared by writing one to the error bit
        else if (wr_stat && hwdata[PFD_ST_CFGERR])
            cfgerr_q <= 1'b0;
    end

    // Output period counter; any write clears it, a count in the same cycle is kept as one
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            per_q <= '0;
        else if (wr_per)
            per_q <= period_end ? 32'h0000_0001 : '0;
        // One per output period; wraps silently when full
        else if (period_end)
            per_q <= per_q + 32'h0000_0001;
    end

    // Status word
    assign stat_word = {n_cnt, 13'h0000, cfgerr_q, run_q, sw_run_q};

    // Read selection; unmapped offsets read zero
    assign rd_mux =
        (rd_addr == PFD_CTRL_OFF) ? {30'h0000_0000, ctrl_q} :
        (rd_addr == PFD_PRE_OFF) ? {24'h00_0000, pre_q} :
        (rd_addr == PFD_NDIV_OFF) ? {16'h0000, ndiv_q} :
        (rd_addr == PFD_SDIV_OFF) ? {16'h0000, sdiv_q} :
        (rd_addr == PFD_STAT_OFF) ? stat_word :
        (rd_addr == PFD_PER_OFF) ? per_q :
        32'h0000_0000;

    // Read data registered so it stands through the data phase
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hrdata_q <= '0;
        // Writes leave the last read data standing
        else if (addr_ok && !hwrite)
            hrdata_q <= rd_mux;
    end

    // Zero wait states: ready from a flop that resets low and goes high on the first clock after reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hready_q <= 1'b0;
        else
            // Never stretches a transfer
            hready_q <= 1'b1;
    end

    // Port drivers, all from flops except hresp, which is tied to okay
    assign hrdata = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp = PFD_HRESP_OKAY;
    assign fb_out = fb_q;
    assign mod_plus1 = sw_run_q;
endmodule

`default_nettype wire

// ==== test/pfd_checker.sv ====
// Checker of the feedback divider: bus answers and output timing.
// Assumes a free-running oscillator with a period of VP bus clocks.
`default_nettype none

module pfd_checker
    import pfd_pkg::*;
#(
    parameter int VP = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Link
    input wire logic vco_in,
    input wire logic fb_out,
    input wire logic mod_plus1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic vp_q; // Last oscillator sample
    logic [3:0] vc_q; // Cycles since oscillator rise, saturating
    logic [7:0] hi_q; // Cycles of feedback high
    // Age of the last oscillator edge and feedback high time
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vp_q <= 1'b0;
            vc_q <= 4'h0;
            hi_q <= 8'h00;
        end
        else
        begin
            vp_q <= vco_in;
            vc_q <= (vco_in && !vp_q) ? 4'h0 : vc_q + {3'h0, vc_q != 4'hf};
            hi_q <= fb_out ? hi_q + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    a_resp_okay: assert property (hresp == PFD_HRESP_OKAY)
        else $error("hresp not okay");
    a_ready_up: assert property ($past(arst_n) |-> hreadyout)
        else $error("hreadyout low");
    // Read data only moves after an accepted read address phase
    a_rdata_hold: assert property (
        !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
        else $error("hrdata moved without read");
    // Outputs move only a few cycles after an oscillator edge
    a_fb_sync: assert property (
        $changed(fb_out) |-> vc_q inside {[2:6]})
        else $error("fb_out not aligned to oscillator");
    a_mod_sync: assert property (
        $changed(mod_plus1) |-> vc_q inside {[2:6]})
        else $error("mod_plus1 not aligned to oscillator");
    a_fb_width: assert property ($fell(fb_out) |-> hi_q == VP)
        else $error("fb_out high time wrong");
    a_fb_gap: assert property ($fell(fb_out) |-> !fb_out [*8])
        else $error("fb_out low time short");
    // Modulus drops mid-period, never as a period starts
    a_mod_fall: assert property (
        $fell(mod_plus1) |-> !$rose(fb_out))
        else $error("mod_plus1 fell at period start");
endmodule

bind pfd_divider pfd_checker i_pfd_checker (.clk(clk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .vco_in(vco_in), .fb_out(fb_out), .mod_plus1(mod_plus1));

`default_nettype wire

// ==== test/pfd_vco_model.sv ====
// Oscillator model: square wave of 2*HALF bus clocks.
// Assumes HALF >= 2 so the divider's synchroniser sees each phase.
`default_nettype none

module pfd_vco_model #(
    parameter int HALF = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Oscillator output
    output logic vco
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt; // Cycles in current phase
    // Free running, like a real oscillator between frames
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vco <= 1'b0;
            cnt <= 0;
        end
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            vco <= !vco;
        end
        else
            cnt <= cnt + 1;
    end
endmodule

`default_nettype wire

// ==== test/testbench.sv ====
// Testbench of the feedback divider: registers and division ratios.
// Assumes the oscillator model runs at one eighth of the bus clock.
`default_nettype none

module testbench
    import pfd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int VP = 8; // Oscillator period in clocks
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    // Bus master signals
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic hreadyout, hresp, vco, fb_out, mod_plus1;
    logic [31:0] hrdata, rd;
    int error_cnt = 0;
    int checks = 0;
    int per, mh;
    // Reset table
    logic [7:0] offs [7] = '{PFD_CTRL_OFF, PFD_PRE_OFF, PFD_NDIV_OFF,
        PFD_SDIV_OFF, PFD_STAT_OFF, PFD_PER_OFF, 8'h18};
    logic [31:0] rstv [7] = '{32'h0, 32'h2, 32'h1c7, 32'h0, 32'h0, 32'h0,
        32'h0};
    assign hready = hreadyout;
    always #4 clk = ~clk;
    pfd_vco_model i_pfd_vco_model (.clk(clk), .arst_n(arst_n), .vco(vco));
    pfd_divider i_pfd_divider (.clk(clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .vco_in(vco), .fb_out(fb_out),
        .mod_plus1(mod_plus1));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        checks++;
        if (seen !== exp)
            $display("mismatch at %0t: got %h want %h", $time, seen,
                exp);
        if (seen !== exp)
            error_cnt++;
    end
    endtask
    // One single word transfer; read data lands in rd
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= PFD_HSIZE_WORD;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    end
    endtask
    // Clocks between two feedback rises, and modulus high time
    task meas(output int p_n, output int m_n);
        logic p;
    begin
        p_n = 0;
        m_n = 0;
        p = 1'b1;
        while (!(fb_out === 1'b1 && p === 1'b0))
        begin
            p = fb_out;
            @(negedge clk);
        end
        do
        begin
            p = fb_out;
            @(negedge clk);
            p_n++;
            if (mod_plus1 === 1'b1)
                m_n++;
        end while (!(fb_out === 1'b1 && p === 1'b0));
    end
    endtask
    task test_done;
    begin
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (offs[i])
        begin
            bus(1'b0, offs[i], 32'h0);
            chk(rd, rstv[i]);
        end
        bus(1'b1, PFD_PRE_OFF, 32'h3);
        bus(1'b1, PFD_NDIV_OFF, 32'h2);
        bus(1'b0, PFD_PRE_OFF, 32'h0);
        chk(rd, 32'h3);
        bus(1'b1, PFD_CTRL_OFF, 32'h1);
        repeat (2) meas(per, mh);
        chk(per, 3 * 2 * VP);
        chk(mh, 0);
        // Four rises seen since enable, one per period end
        bus(1'b0, PFD_PER_OFF, 32'h0);
        chk(rd, 32'h4);
        bus(1'b1, PFD_PER_OFF, 32'h0);
        bus(1'b0, PFD_PER_OFF, 32'h0);
        chk(rd, 32'h0);
        // Ratios change while running, taken at a period end
        bus(1'b1, PFD_PRE_OFF, 32'h2);
        bus(1'b1, PFD_NDIV_OFF, 32'h3);
        bus(1'b1, PFD_CTRL_OFF, 32'h3);
        for (int s = 1; s <= 3; s++)
        begin
            bus(1'b1, PFD_SDIV_OFF, s);
            repeat (3) meas(per, mh);
            chk(per, (s < 3 ? 6 + s : 9) * VP);
            chk(mh, s * 3 * VP);
        end
        bus(1'b0, PFD_STAT_OFF, 32'h0);
        chk(rd[2:0], 3'h7);
        bus(1'b1, PFD_SDIV_OFF, 32'h1);
        repeat (2) meas(per, mh);
        chk(per, 7 * VP);
        chk(mh, 3 * VP);
        // Error stays set after the setup is mended
        bus(1'b0, PFD_STAT_OFF, 32'h0);
        chk(rd[2:1], 2'h3);
        bus(1'b1, PFD_STAT_OFF, 32'h4);
        bus(1'b0, PFD_STAT_OFF, 32'h0);
        chk(rd[PFD_ST_CFGERR], 1'b0);
        // Second reset in mid-run
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        bus(1'b0, PFD_CTRL_OFF, 32'h0);
        chk(rd, 32'h0);
        chk(fb_out, 1'b0);
        test_done;
    end
    // Watchdog against a stuck divider or bus
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done;
    end
endmodule

`default_nettype wire
